//--- verilog/ssr_consts.vh
// Constants for the serial-in, parallel-out shift and storage register.
// Definitions only; included by the design file.
`ifndef SSR_CONSTS_VH
`define SSR_CONSTS_VH
`define SSR_WIDTH 8
`define SSR_CLEAR_VAL 8'h00
`define SSR_BUF_DEPTH 2
`endif

//--- verilog/ssr_top.v
// Serial-in, parallel-out shift register feeding a storage register,
// with a cascade output and a two-entry buffer on the word path.
// Assumes shift_clock and store_clock are strobes synchronous to clock.
`include "ssr_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module ssr_top #(
    parameter WIDTH = `SSR_WIDTH
) (
    // System
    input wire clock,
    input wire rst_n,
    // Serial side
    input wire serial_in,
    input wire shift_clock,
    input wire shift_clear_n,
    // Storage side
    input wire store_clock,
    input wire store_clear_n,
    // Outputs
    output wire [WIDTH-1:0] parallel_out,
    output wire cascade_out,
    // Word stream of each stored pattern taken while the buffer is not full
    output wire word_valid,
    output wire [WIDTH-1:0] word_data,
    input wire word_ready,
    output wire store_ready
);

    reg [WIDTH-1:0] shift_r;
    reg [WIDTH-1:0] shift_nxt;
    reg [WIDTH-1:0] store_r;
    reg [WIDTH-1:0] store_nxt;
    reg shift_clk_d_r;
    reg store_clk_d_r;
    wire shift_rise;
    wire store_rise;
    wire store_take;

    // Edge detect on the clock strobes; levels and falls do nothing
    assign shift_rise = shift_clock & ~shift_clk_d_r;
    assign store_rise = store_clock & ~store_clk_d_r;

    always @(posedge clock) begin
        if (!rst_n) begin
            shift_clk_d_r <= 1'b0;
            store_clk_d_r <= 1'b0;
        end else begin
            shift_clk_d_r <= shift_clock;
            store_clk_d_r <= store_clock;
        end
    end

    // Shift stage next value; clear wins over any edge
    always @* begin
        if (!shift_clear_n) begin
            shift_nxt = `SSR_CLEAR_VAL;
        end else if (shift_rise) begin
            shift_nxt = {shift_r[WIDTH-2:0], serial_in};
        end else begin
            shift_nxt = shift_r;
        end
    end

    // Storage next value uses the old shift state, so tied clocks lag one pulse
    always @* begin
        if (!store_clear_n) begin
            store_nxt = `SSR_CLEAR_VAL;
        end else if (store_rise) begin
            store_nxt = shift_r;
        end else begin
            store_nxt = store_r;
        end
    end

    // Separate processes keep the two registers independent
    always @(posedge clock) begin
        if (!rst_n) begin
            shift_r <= `SSR_CLEAR_VAL;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            store_r <= `SSR_CLEAR_VAL;
        end else begin
            store_r <= store_nxt;
        end
    end

    // Stage 0 is the first stage; cascade is the last stage
    assign parallel_out = store_r;
    assign cascade_out = shift_r[WIDTH-1];

    // Each storage load is offered as a word; a full buffer drops none silently
    // but a load while full is not queued, so store_ready tells the controller
    assign store_take = store_rise & store_clear_n;

    ssr_buf #(
        .WIDTH(WIDTH)
    ) u_buf (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(store_take),
        .in_data(shift_r),
        .in_ready(store_ready),
        .out_valid(word_valid),
        .out_data(word_data),
        .out_ready(word_ready)
    );

endmodule // ssr_top

// Two-entry FIFO of flip-flops with valid/ready on both sides
module ssr_buf #(
    parameter WIDTH = `SSR_WIDTH
) (
    input wire clock,
    input wire rst_n,
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output wire in_ready,
    output wire out_valid,
    output wire [WIDTH-1:0] out_data,
    input wire out_ready
);

    reg [WIDTH-1:0] mem_r [0:`SSR_BUF_DEPTH-1];
    reg wr_ptr_r;
    reg rd_ptr_r;
    reg [1:0] count_r;
    wire push;
    wire pop;

    assign in_ready = (count_r != 2'h2);
    assign out_valid = (count_r != 2'h0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Pointers and occupancy
    always @(posedge clock) begin
        if (!rst_n) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // Storage, written only on accepted pushes
    always @(posedge clock) begin
        if (!rst_n) begin
            mem_r[0] <= `SSR_CLEAR_VAL;
            mem_r[1] <= `SSR_CLEAR_VAL;
        end else if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

endmodule // ssr_buf

`default_nettype wire

//--- tb/ssr_checker.sv
// Port checker for ssr_top; strobes are levels sampled on clock
`timescale 1ns/1ps
`default_nettype none
module ssr_checker (
    input wire logic clock, rst_n, shift_clock, shift_clear_n, store_clock, store_clear_n,
    input wire logic word_ready, cascade_out, word_valid, store_ready,
    input wire logic [7:0] parallel_out, word_data
);
    reg ps_r, pt_r;
    // Strobe levels one edge back, for rise detection
    always @(posedge clock) {ps_r, pt_r} <= {shift_clock, store_clock};
    wire sr = shift_clock & ~ps_r, tr = store_clock & ~pt_r & store_clear_n;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    s_clr_a: assert property (!shift_clear_n |=> !cascade_out) else $error("c");
    s_hold_a: assert property (shift_clear_n && !sr |=> $stable(cascade_out))
        else $error("h");
    t_clr_a: assert property (!store_clear_n |=> !parallel_out) else $error("c");
    t_hold_a: assert property (store_clear_n && !tr |=> $stable(parallel_out))
        else $error("h");
    t_copy_a: assert property (tr |=> parallel_out[7] == $past(cascade_out))
        else $error("p");
    w_push_a: assert property (tr && store_ready |=> word_valid) else $error("w");
    w_stall_a: assert property (word_valid && !word_ready |=> $stable(word_data))
        else $error("s");
    w_head_a: assert property (tr && !word_valid |=> word_data == parallel_out)
        else $error("d");
endmodule // ssr_checker
`default_nettype wire

//--- tb/ssr_host.sv
// Far-side host model; runs on the bench clock
`timescale 1ns/1ps
`default_nettype none
module ssr_host (
    input wire logic clock,
    output logic serial_in, shift_clock, shift_clear_n, store_clock, store_clear_n
);
    // Idle: strobes low, clears released
    initial {serial_in, shift_clock, shift_clear_n, store_clock, store_clear_n} = 5'h05;
    // One strobe cycle then one low; data inverted once taken
    task pulse(input s, t, d, c, e);
        @(posedge clock);
        {serial_in, shift_clock, store_clock, shift_clear_n, store_clear_n} <= {d, s, t, c, e};
        @(posedge clock);
        {serial_in, shift_clock, store_clock} <= {~d, 2'h0};
    endtask
endmodule // ssr_host
`default_nettype wire

//--- tb/ssr_tb_top.sv
// Bench top for ssr_top with host model, checker and reference model
`timescale 1ns/1ps
`default_nettype none
module ssr_tb_top;
    logic clock = 0, rst_n = 0, word_ready = 0;
    bit [7:0] sh, st, q[$];
    logic [31:0] r = 32'hB69F;
    int num_errors, n_compared;
    wire serial_in, shift_clock, shift_clear_n, store_clock, store_clear_n;
    wire cascade_out, word_valid, store_ready;
    wire [7:0] parallel_out, word_data;
    ssr_top ssr_top_i (.*);
    ssr_host ssr_host_i (.*);
    initial forever #2 clock = ~clock;
    task chk(input logic [7:0] a, b);
        n_compared++;
        if (a !== b) num_errors++;
        if (a !== b) $display("MISMATCH %0t seen %h expected %h", $time, a, b);
    endtask
    task close_out;
        $display("errors %0d of %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Model on pre-edge values; host strobes last one cycle, so high means rise
    always @(posedge clock) if (rst_n) begin
        chk(parallel_out, st);
        chk(cascade_out, sh[7]);
        chk(store_ready, q.size() != 2);
        chk(word_valid, q.size() != 0);
        if (word_valid && word_ready) chk(word_data, q.pop_front());
        if (!store_clear_n) st = 0;
        else if (store_clock) begin
            st = sh;
            if (store_ready) q.push_back(sh);
        end
        if (!shift_clear_n) sh = 0;
        else if (shift_clock) sh = {sh[6:0], serial_in};
    end
    // Sink stalls at first, so the buffer fills and refuses
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1;
        for (int i = 0; i < 400; i++) begin
            r = nx(r);
            word_ready <= i > 99 && r[7];
            ssr_host_i.pulse(r[0], r[1], r[2], |r[5:3], |r[8:6]);
        end
        word_ready <= 1;
        repeat (8) @(posedge clock);
        chk(word_valid, 8'h00);
        close_out;
    end
endmodule // ssr_tb_top
bind ssr_top ssr_checker ssr_checker_i (.*);
`default_nettype wire
